/* File: psd_defs.svh */
`ifndef PSD_DEFS_SVH
`define PSD_DEFS_SVH

`define PSD_OFF_TABLE_PAGE   12'h000
`define PSD_OFF_VIS_PAGE     12'h004
`define PSD_OFF_CORE_CTRL    12'h008
`define PSD_OFF_STATUS       12'h00C
`define PSD_OFF_LAST_ADDR    12'h010
`define PSD_OFF_LAST_DATA    12'h014
`define PSD_OFF_GEOMETRY     12'h018

`define PSD_CTRL_REMAP_BIT   2
`define PSD_PAGE_TOP_BIT     7
`define PSD_WINDOW_BIT       15
`define PSD_PADDR_TOP_BIT    23
`define PSD_PAGE_RESET       8'h00
`define PSD_CTRL_RESET       16'h0000

`define PSD_ROW_INSTR        16'h0040
`define PSD_ERASE_INSTR      16'h0200
`define PSD_ROW_BYTES        16'h00C0
`define PSD_ERASE_BYTES      16'h0600

`define PSD_STALL_NONE       2'h0
`define PSD_STALL_ONE        2'h1
`define PSD_STALL_TWO        2'h2

`endif

/* File: psd_pkg.sv */
package psd_pkg;
    typedef enum logic [2:0] {
        PSD_OP_NONE,
        PSD_OP_DATA_READ,
        PSD_OP_TABLE_READ_LOW,
        PSD_OP_TABLE_READ_HIGH,
        PSD_OP_TABLE_WRITE_LOW,
        PSD_OP_TABLE_WRITE_HIGH,
        PSD_OP_FETCH
    } psd_op_t;

    typedef enum logic [1:0] {
        PSD_LOOP_NONE,
        PSD_LOOP_EDGE,
        PSD_LOOP_MIDDLE
    } psd_loop_t;

    typedef enum {
        PSD_ST_IDLE,
        PSD_ST_STALL
    } psd_state_t;
endpackage

/* File: psd_bridge.sv */
`include "psd_defs.svh"

// Functional notes
// - table address is table page above the 16-bit operand address, 24 bits
// - table page top bit 0 selects user memory, 1 selects configuration memory
// - remap address is visibility page above low 15 operand address bits
// - remap path always forces program address bit 23 to zero
// - remap ignores operand bit 15; program bit 15 is visibility page bit 0
// - remap only when operand top bit and core control bit 2 are set
// - every data address from 8000h maps to a program word when enabled
// - visibility page picks one of 256 pages of 16K words
// - remapped reads return only the low 16 bits of the program word
// - program words advance by two; low and high lanes share addresses
// - low-lane word table read returns program bits 15 to 0
// - low-lane byte read returns upper byte if select 1, else lower
// - high-lane word read returns bits 23 to 16, upper result byte zero
// - high-lane byte read with select 1 returns zero
// - remapped read adds stall cycles, except on middle loop iterations, since two fetches are needed
// - remap is suspended during any table read or write
// - outside loops: copy instrs one extra cycle, others two
// - in loops: first, last, interrupt exit, re-entry cost two cycles
// - other loop iterations complete the remapped access without stall
// - writes are one word or 64-instruction rows; erase 512 instructions (code does single-word table writes only; geometry reports 64 and 512)
// - table address comes from table page bits 7 to 0 plus operand address
module psd_bridge
    import psd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        core_req,
    input  wire psd_op_t     core_op,
    input  wire logic [15:0] operand_addr,
    input  wire logic        core_byte_mode,
    input  wire logic [15:0] core_wdata,
    input  wire logic [22:0] core_pc,
    input  wire logic        copy_instr,
    input  wire psd_loop_t   core_loop,
    output logic             core_stall,
    output logic             core_done,
    output logic [15:0]      core_rdata,
    output logic [23:0]      prog_instr,
    output logic             mem_req,
    output logic             mem_we,
    output logic             mem_config,
    output logic [23:0]      mem_addr,
    output logic [23:0]      mem_wdata,
    output logic [2:0]       mem_wlanes,
    input  wire logic [23:0] mem_rdata
);

    logic [7:0]  table_page_q;
    logic [7:0]  table_page_d;
    logic [7:0]  visibility_page_q;
    logic [7:0]  visibility_page_d;
    logic [15:0] core_control_reg_q;
    logic [15:0] core_control_reg_d;
    logic [23:0] last_addr_q;
    logic [23:0] last_addr_d;
    logic [15:0] last_data_q;
    logic [15:0] last_data_d;
    logic [7:0]  remap_count_q;
    logic [7:0]  remap_count_d;
    psd_state_t  state_q;
    psd_state_t  state_d;
    logic [1:0]  stall_q;
    logic [1:0]  stall_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        done_q;
    logic        done_d;

    logic        remap_enable;
    logic        is_table;
    logic        is_remap;
    logic        byte_sel;
    logic [23:0] table_addr;
    logic [23:0] remap_addr;
    logic [15:0] read_result;
    logic [1:0]  stall_need;
    logic        apb_wr;

    assign apb_wr  = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    assign remap_enable = core_control_reg_q[`PSD_CTRL_REMAP_BIT];
    assign is_table     = (core_op == PSD_OP_TABLE_READ_LOW) ||
                          (core_op == PSD_OP_TABLE_READ_HIGH) ||
                          (core_op == PSD_OP_TABLE_WRITE_LOW) ||
                          (core_op == PSD_OP_TABLE_WRITE_HIGH);
    // data reads from 8000h up with enable set go to program space
    assign is_remap     = (core_op == PSD_OP_DATA_READ) && !is_table &&
                          operand_addr[`PSD_WINDOW_BIT] && remap_enable;
    assign byte_sel     = core_byte_mode && operand_addr[0];
    assign table_addr   = {table_page_q, operand_addr};
    assign remap_addr   = {1'b0, visibility_page_q,
                           operand_addr[`PSD_WINDOW_BIT - 1:0]};

    // lane and byte selection of returned word
    always_comb
    begin
        read_result = mem_rdata[15:0];
        if (core_op == PSD_OP_TABLE_READ_LOW && core_byte_mode)
        begin
            read_result = {8'h00, byte_sel ? mem_rdata[15:8] : mem_rdata[7:0]};
        end
        else if (core_op == PSD_OP_TABLE_READ_HIGH)
        begin
            read_result = (core_byte_mode && byte_sel) ? 16'h0000
                                                        : {8'h00, mem_rdata[23:16]};
        end
    end

    // extra cycles for remapped accesses
    always_comb
    begin
        stall_need = `PSD_STALL_NONE;
        if (is_remap)
        begin
            unique case (core_loop)
                PSD_LOOP_NONE:   stall_need = copy_instr ? `PSD_STALL_ONE
                                                         : `PSD_STALL_TWO;
                PSD_LOOP_EDGE:   stall_need = `PSD_STALL_TWO;
                PSD_LOOP_MIDDLE: stall_need = `PSD_STALL_NONE;
            endcase
        end
    end

    // memory port
    always_comb
    begin
        mem_req    = core_req && (is_table || is_remap || core_op == PSD_OP_FETCH);
        mem_we     = core_req && (core_op == PSD_OP_TABLE_WRITE_LOW ||
                                  core_op == PSD_OP_TABLE_WRITE_HIGH);
        mem_config = is_table && table_page_q[`PSD_PAGE_TOP_BIT];
        mem_addr   = table_addr;
        if (is_remap)
        begin
            mem_addr = remap_addr;
        end
        else if (core_op == PSD_OP_FETCH)
        begin
            mem_addr = {1'b0, core_pc[22:1], 1'b0};
        end
        mem_wdata  = {core_wdata[7:0], core_wdata};
        mem_wlanes = 3'h0;
        if (core_op == PSD_OP_TABLE_WRITE_LOW)
        begin
            mem_wlanes = core_byte_mode ? (byte_sel ? 3'h2 : 3'h1) : 3'h3;
            mem_wdata  = byte_sel ? {8'h00, core_wdata[7:0], 8'h00}
                                  : {8'h00, core_wdata};
        end
        else if (core_op == PSD_OP_TABLE_WRITE_HIGH)
        begin
            mem_wlanes = (core_byte_mode && byte_sel) ? 3'h0 : 3'h4;
        end
    end

    assign prog_instr = mem_rdata;
    assign core_stall = core_req && (state_q == PSD_ST_IDLE) && (stall_need != `PSD_STALL_NONE)
                        || (state_q == PSD_ST_STALL);
    assign core_done  = done_q;
    assign core_rdata = rdata_q;

    // request sequencing
    always_comb
    begin
        state_d       = state_q;
        stall_d       = stall_q;
        rdata_d       = rdata_q;
        done_d        = 1'b0;
        last_addr_d   = last_addr_q;
        last_data_d   = last_data_q;
        remap_count_d = remap_count_q;
        unique case (state_q)
            PSD_ST_IDLE:
            begin
                if (core_req && core_op != PSD_OP_NONE)
                begin
                    last_addr_d = mem_addr;
                    rdata_d     = read_result;
                    last_data_d = read_result;
                    if (is_remap)
                    begin
                        remap_count_d = remap_count_q + 8'h01;
                    end
                    if (stall_need != `PSD_STALL_NONE)
                    begin
                        state_d = PSD_ST_STALL;
                        stall_d = stall_need - `PSD_STALL_ONE;
                    end
                    else
                    begin
                        done_d = 1'b1;
                    end
                end
            end
            PSD_ST_STALL:
            begin
                if (stall_q == `PSD_STALL_NONE)
                begin
                    state_d = PSD_ST_IDLE;
                    done_d  = 1'b1;
                end
                else
                begin
                    stall_d = stall_q - `PSD_STALL_ONE;
                end
            end
        endcase
    end

    // register writes
    always_comb
    begin
        table_page_d       = table_page_q;
        visibility_page_d  = visibility_page_q;
        core_control_reg_d = core_control_reg_q;
        if (apb_wr)
        begin
            unique case (paddr)
                `PSD_OFF_TABLE_PAGE: table_page_d       = pwdata[7:0];
                `PSD_OFF_VIS_PAGE:   visibility_page_d  = pwdata[7:0];
                `PSD_OFF_CORE_CTRL:  core_control_reg_d = pwdata[15:0];
                default:             ;
            endcase
        end
    end

    // register reads
    always_comb
    begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `PSD_OFF_TABLE_PAGE: prdata = {24'h000000, table_page_q};
            `PSD_OFF_VIS_PAGE:   prdata = {24'h000000, visibility_page_q};
            `PSD_OFF_CORE_CTRL:  prdata = {16'h0000, core_control_reg_q};
            `PSD_OFF_STATUS:     prdata = {16'h0000, remap_count_q, 5'h00,
                                           state_q == PSD_ST_STALL, stall_q};
            `PSD_OFF_LAST_ADDR:  prdata = {8'h00, last_addr_q};
            `PSD_OFF_LAST_DATA:  prdata = {16'h0000, last_data_q};
            `PSD_OFF_GEOMETRY:   prdata = {`PSD_ERASE_INSTR, `PSD_ROW_INSTR};
            default:             prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            table_page_q       <= `PSD_PAGE_RESET;
            visibility_page_q  <= `PSD_PAGE_RESET;
            core_control_reg_q <= `PSD_CTRL_RESET;
            state_q            <= PSD_ST_IDLE;
            stall_q            <= `PSD_STALL_NONE;
            rdata_q            <= 16'h0000;
            done_q             <= 1'b0;
            last_addr_q        <= 24'h000000;
            last_data_q        <= 16'h0000;
            remap_count_q      <= 8'h00;
        end
        else
        begin
            table_page_q       <= table_page_d;
            visibility_page_q  <= visibility_page_d;
            core_control_reg_q <= core_control_reg_d;
            state_q            <= state_d;
            stall_q            <= stall_d;
            rdata_q            <= rdata_d;
            done_q             <= done_d;
            last_addr_q        <= last_addr_d;
            last_data_q        <= last_data_d;
            remap_count_q      <= remap_count_d;
        end
    end

    property p_remap_top_zero;
        @(posedge pclk) disable iff (!presetn)
        is_remap |-> (mem_addr[`PSD_PADDR_TOP_BIT] == 1'b0) && !mem_config;
    endproperty
    a_remap_top_zero: assert property (p_remap_top_zero)
        else $error("remap address bit 23 not clear");

    property p_remap_page_bit;
        @(posedge pclk) disable iff (!presetn)
        is_remap |-> mem_addr[15] == visibility_page_q[0]
            && mem_addr[22:16] == visibility_page_q[7:1];
    endproperty
    a_remap_page_bit: assert property (p_remap_page_bit)
        else $error("remap page bits misplaced");

    property p_table_addr;
        @(posedge pclk) disable iff (!presetn)
        (core_req && is_table) |-> mem_addr == {table_page_q, operand_addr}
            && mem_config == table_page_q[7];
    endproperty
    a_table_addr: assert property (p_table_addr)
        else $error("table address wrong");

    property p_no_remap_when_off;
        @(posedge pclk) disable iff (!presetn)
        (!remap_enable || !operand_addr[15]) |-> !is_remap;
    endproperty
    a_no_remap_when_off: assert property (p_no_remap_when_off)
        else $error("remap without enable");

    property p_high_phantom;
        @(posedge pclk) disable iff (!presetn)
        (core_op == PSD_OP_TABLE_READ_HIGH) |-> read_result[15:8] == 8'h00;
    endproperty
    a_high_phantom: assert property (p_high_phantom)
        else $error("phantom byte not zero");

    property p_copy_one_stall;
        @(posedge pclk) disable iff (!presetn)
        (state_q == PSD_ST_IDLE && core_req && is_remap && copy_instr
            && core_loop == PSD_LOOP_NONE)
            |=> core_stall ##1 (core_done && !core_stall);
    endproperty
    a_copy_one_stall: assert property (p_copy_one_stall)
        else $error("copy remap stall length wrong");

    property p_edge_two_stall;
        @(posedge pclk) disable iff (!presetn)
        (state_q == PSD_ST_IDLE && core_req && is_remap && core_loop == PSD_LOOP_EDGE)
            |=> core_stall [*2] ##1 core_done;
    endproperty
    a_edge_two_stall: assert property (p_edge_two_stall)
        else $error("loop edge stall length wrong");

    property p_middle_nostall;
        @(posedge pclk) disable iff (!presetn)
        (state_q == PSD_ST_IDLE && core_req && is_remap && core_loop == PSD_LOOP_MIDDLE)
            |-> !core_stall ##1 core_done;
    endproperty
    a_middle_nostall: assert property (p_middle_nostall)
        else $error("loop middle stalled");

    property p_other_two_stall;
        @(posedge pclk) disable iff (!presetn)
        (state_q == PSD_ST_IDLE && core_req && is_remap && !copy_instr
            && core_loop == PSD_LOOP_NONE) |=> core_stall [*2] ##1 core_done;
    endproperty
    a_other_two_stall: assert property (p_other_two_stall)
        else $error("remap stall length wrong");

    property p_remap_low_word;
        @(posedge pclk) disable iff (!presetn)
        is_remap |-> read_result == mem_rdata[15:0];
    endproperty
    a_remap_low_word: assert property (p_remap_low_word)
        else $error("remap read not low word");

    property p_low_byte;
        @(posedge pclk) disable iff (!presetn)
        (core_op == PSD_OP_TABLE_READ_LOW && core_byte_mode)
            |-> read_result == {8'h00, operand_addr[0] ? mem_rdata[15:8] : mem_rdata[7:0]};
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low byte select wrong");

    property p_fetch_addr;
        @(posedge pclk) disable iff (!presetn)
        (core_req && core_op == PSD_OP_FETCH)
            |-> mem_addr == {1'b0, core_pc[22:1], 1'b0} && !mem_config;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr)
        else $error("fetch address wrong");

endmodule // psd_bridge

/* File: psd_mem_model.sv */
module psd_mem_model
(
    input  wire logic        pclk,
    input  wire logic        mem_req,
    input  wire logic [23:0] mem_addr,
    output logic      [23:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] junk_q = 24'h000000;
    // when not selected, read data is junk_q, negated each cycle from zero, so it stays zero
    always @(posedge pclk)
        junk_q <= ~junk_q + 24'h000001;
    // upper byte filled all ones or all zeros
    always_comb
    begin
        if (mem_req)
            mem_rdata = {{8{mem_addr[1] ^ mem_addr[9]}}, mem_addr[15:0] ^ 16'hC35A};
        else
            mem_rdata = junk_q;
    end
endmodule // psd_mem_model

/* File: program_space_data_access_tb.sv */
`include "psd_defs.svh"
module program_space_data_access_tb import psd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready, pslverr, core_stall, core_done, mem_req, mem_we, mem_config;
    logic        core_req = 1'h0;
    psd_op_t     core_op = PSD_OP_NONE;
    psd_loop_t   core_loop = PSD_LOOP_NONE;
    logic [15:0] operand_addr = 16'h0000;
    logic        core_byte_mode = 1'h0;
    logic        copy_instr = 1'h0;
    logic [15:0] core_wdata = 16'h0000;
    logic [22:0] core_pc = 23'h000000;
    logic [15:0] core_rdata;
    logic [23:0] prog_instr, mem_addr, mem_wdata, mem_rdata;
    logic [2:0]  mem_wlanes;
    int          err_total = 0;
    int          n_tests = 0;
    logic [31:0] rnd_s = 32'hC31586EE;
    logic [31:0] r;
    logic [16:0] e;
    logic [16:0] exp_q[$];
    logic [7:0]  tp_s = 8'h00;
    logic [7:0]  vp_s = 8'h00;
    logic        en_s = 1'h0;
    logic [7:0]  rc_s = 8'h00;
    always #5 pclk = ~pclk;
    psd_bridge uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req), .core_op(core_op),
        .operand_addr(operand_addr), .core_byte_mode(core_byte_mode),
        .core_wdata(core_wdata), .core_pc(core_pc), .copy_instr(copy_instr),
        .core_loop(core_loop), .core_stall(core_stall), .core_done(core_done),
        .core_rdata(core_rdata), .prog_instr(prog_instr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_config(mem_config), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_wlanes(mem_wlanes), .mem_rdata(mem_rdata));
    psd_mem_model flash (.pclk(pclk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata));
    function automatic logic [31:0] xs();
        rnd_s = rnd_s ^ (rnd_s << 13);
        rnd_s = rnd_s ^ (rnd_s >> 17);
        rnd_s = rnd_s ^ (rnd_s << 5);
        return rnd_s;
    endfunction
    function automatic logic [23:0] mem_word(input logic [23:0] a);
        return {{8{a[1] ^ a[9]}}, a[15:0] ^ 16'hC35A};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] ex);
        n_tests++;
        if (seen !== ex)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, ex, seen);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        check("pslverr", pslverr, 0);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic core_run(input psd_op_t op, input logic [15:0] ea, input logic bm,
                            input psd_loop_t lp, input logic cp);
        logic [23:0] a;
        logic [23:0] w;
        logic [16:0] rx;
        logic [2:0]  ln;
        logic [15:0] wd;
        logic [22:0] pc;
        logic        rm;
        logic        tbl;
        int          n;
        int          k;
        wd = 16'(xs());
        pc = 23'(xs());
        rm = (op == PSD_OP_DATA_READ) && ea[15] && en_s;
        tbl = op inside {PSD_OP_TABLE_READ_LOW, PSD_OP_TABLE_READ_HIGH,
                         PSD_OP_TABLE_WRITE_LOW, PSD_OP_TABLE_WRITE_HIGH};
        n = !rm ? 0 : (lp == PSD_LOOP_MIDDLE) ? 0 : (lp == PSD_LOOP_EDGE || !cp) ? 2 : 1;
        if (rm)
            rc_s = rc_s + 8'h01;
        if (op == PSD_OP_DATA_READ)
            a = {1'h0, vp_s, ea[14:0]};
        else if (op == PSD_OP_FETCH)
            a = {1'h0, pc[22:1], 1'h0};
        else
            a = {tp_s, ea};
        w = mem_word(a);
        rx = 17'h00000;
        ln = 3'h0;
        case (op)
            PSD_OP_DATA_READ: rx = {rm, w[15:0]};
            PSD_OP_TABLE_READ_LOW: rx = {1'h1, bm ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w[15:0]};
            PSD_OP_TABLE_READ_HIGH: rx = {1'h1, 8'h00, (bm && ea[0]) ? 8'h00 : w[23:16]};
            PSD_OP_TABLE_WRITE_LOW: ln = bm ? (ea[0] ? 3'h2 : 3'h1) : 3'h3;
            PSD_OP_TABLE_WRITE_HIGH: ln = (bm && ea[0]) ? 3'h0 : 3'h4;
            default: ;
        endcase
        @(posedge pclk);
        core_req <= 1'h1;
        core_op <= op;
        operand_addr <= ea;
        core_byte_mode <= bm;
        core_loop <= lp;
        copy_instr <= cp;
        core_wdata <= wd;
        core_pc <= pc;
        exp_q.push_back(rx);
        @(negedge pclk);
        if (op == PSD_OP_DATA_READ && !rm)
            check("mem_req", mem_req, 0);
        else if (!(op == PSD_OP_TABLE_WRITE_HIGH && ln == 3'h0))
            check("mem_addr", mem_addr, a);
        if (tbl)
            check("mem_config", mem_config, tp_s[7]);
        if (op == PSD_OP_TABLE_WRITE_LOW || op == PSD_OP_TABLE_WRITE_HIGH)
            check("mem_wlanes", mem_wlanes, ln);
        check("mem_we", mem_we, tbl && rx == 17'h00000);
        check("core_stall", core_stall, n != 0);
        if (op == PSD_OP_TABLE_WRITE_LOW && !bm)
            check("mem_wdata", mem_wdata[15:0], wd);
        if (op == PSD_OP_FETCH)
            check("prog_instr", prog_instr, w);
        @(posedge pclk);
        core_req <= 1'h0;
        k = 1;
        @(negedge pclk);
        while (core_done !== 1'h1 && k < 8)
        begin
            @(negedge pclk);
            k++;
        end
        check("latency", k, n + 1);
        apb(1'h0, `PSD_OFF_LAST_ADDR, 32'h00000000);
        if (!(op == PSD_OP_DATA_READ && !rm))
            check("last_addr", r, {8'h00, a});
        apb(1'h0, `PSD_OFF_LAST_DATA, 32'h00000000);
        if (rx[16])
            check("last_data", r, {16'h0000, rx[15:0]});
        apb(1'h0, `PSD_OFF_STATUS, 32'h00000000);
        check("status", r, {16'h0000, rc_s, 8'h00});
    endtask
    // result monitor: oldest note against each completion
    always @(negedge pclk)
    begin
        if (core_done === 1'h1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            if (e[16])
                check("core_rdata", core_rdata, e[15:0]);
        end
    end
    initial
    begin
        #100000;
        err_total++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `PSD_OFF_TABLE_PAGE, 32'h00000000);
        check("table_page reset", r, 0);
        apb(1'h0, `PSD_OFF_VIS_PAGE, 32'h00000000);
        check("visibility_page reset", r, 0);
        apb(1'h0, `PSD_OFF_CORE_CTRL, 32'h00000000);
        check("core_control_reg reset", r, 0);
        apb(1'h0, 12'h020, 32'h00000000);
        check("unmapped", r, 0);
        apb(1'h0, `PSD_OFF_GEOMETRY, 32'h00000000);
        check("geometry", r, {`PSD_ERASE_INSTR, `PSD_ROW_INSTR});
        for (int i = 0; i < 54; i++)
        begin
            tp_s = 8'(xs());
            vp_s = 8'(xs());
            en_s = (i >= 48) | ((xs() >> 31) != 32'h00000000);
            apb(1'h1, `PSD_OFF_TABLE_PAGE, {24'h000000, tp_s});
            apb(1'h1, `PSD_OFF_VIS_PAGE, {24'h000000, vp_s});
            apb(1'h1, `PSD_OFF_CORE_CTRL, {29'h00000000, en_s, 2'h0});
            apb(1'h0, `PSD_OFF_VIS_PAGE, 32'h00000000);
            check("visibility_page", r, {24'h000000, vp_s});
            apb(1'h0, `PSD_OFF_TABLE_PAGE, 32'h00000000);
            check("table_page", r, {24'h000000, tp_s});
            if (i < 48)
                core_run(psd_op_t'(1 + i % 6), 16'(xs()), 1'(xs() >> 31),
                         psd_loop_t'(xs() % 3), 1'(xs() >> 31));
            else
                core_run(PSD_OP_DATA_READ, 16'(xs()) | 16'h8000, 1'h0,
                         psd_loop_t'((i - 48) / 2), i[0]);
        end
        stop_test();
    end
endmodule // program_space_data_access_tb
